// file: src/eirq_top.sv
// Notes on behaviour
// (RULE1) Pin serves interrupt only when enable set
// (RULE2) Qualifying pin activity sets the request latch
// (RULE3) Falling-edge after reset; mode adds low-level
// (RULE4) Vector fetch acknowledge clears the latch
// (RULE5) Writing one to acknowledge clears latch
// (RULE6) Reset clears latch; otherwise it stays set
// (RULE7) Local mask withholds latched request
// (RULE8) Global processor mask also blocks request
// (RULE9) Level mode: low pin keeps request asserted
module eirq_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [eirq_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [eirq_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [eirq_pkg::BE_W-1:0] avs_byteenable_i,
  output logic [eirq_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic irq_pin_n_i,
  input wire logic vector_fetch_i,
  input wire logic ccr_int_mask_i,
  output logic cpu_irq_req_o,
  output logic irq_function_active_o,
  output logic shared_port_a_bit_two_o,
  output logic intr_o
);
  import eirq_pkg::*;

  // ----------------------------------------
  // Decode helper
  // ----------------------------------------
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  eirq_acc_type acc;
  logic [DATA_W-1:0] rdata;
  logic wr_lane0;
  logic pin_fall;
  logic pin_low;
  logic latch_set;
  logic latch_clr;
  logic sw_ack;
  logic irq_function_enable_ff;
  eirq_sens_type sens_ff;
  logic irq_request_mask_ff;
  logic latch_ff;
  logic [EV_W-1:0] ev_stat_ff;
  logic [EV_W-1:0] ev_mask_ff;
  logic [EV_W-1:0] ev_pulse;
  logic cpu_irq_req_ff;
  logic active_ff;
  logic port_ff;
  logic intr_ff;

  // ----------------------------------------
  // Bus slave and pin sampling
  // ----------------------------------------
  eirq_avs_slave u_slave (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .read_i(avs_read_i),
    .write_i(avs_write_i),
    .address_i(avs_address_i),
    .writedata_i(avs_writedata_i),
    .byteenable_i(avs_byteenable_i),
    .rdata_i(rdata),
    .acc_o(acc),
    .readdata_o(avs_readdata_o),
    .waitrequest_o(avs_waitrequest_o)
  );

  eirq_pin_sense u_sense (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .enable_i(irq_function_enable_ff),
    .pin_n_i(irq_pin_n_i),
    .fall_o(pin_fall),
    .low_o(pin_low)
  );

  // All fields live in byte lane 0
  assign wr_lane0 = acc.wr && acc.be[LANE0_BIT];

  wait_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && !avs_waitrequest_o
    |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");

  wait_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && avs_waitrequest_o && !avs_read_i && !avs_write_i
    |=> avs_waitrequest_o)
    else $error("waitrequest dropped without a request");

  read_data_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && avs_read_i && avs_waitrequest_o
    |=> avs_readdata_o == $past(rdata))
    else $error("read data not taken from the addressed register");

  ack_reads_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE5
    ce_i && avs_read_i && avs_waitrequest_o && avs_address_i == OFS_SCR
    |=> !avs_readdata_o[SCR_ACK_BIT])
    else $error("acknowledge bit read back as one");

  lane_skip_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && acc.wr && !acc.be[LANE0_BIT]
    |=> $stable(irq_function_enable_ff) && $stable(irq_request_mask_ff) && $stable(ev_mask_ff))
    else $error("write without lane 0 changed a register");

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    rdata = RDATA_ZERO;
    if (reg_hit(avs_address_i, OFS_SCR)) begin
      rdata[SCR_MODE_BIT] = sens_ff;
      rdata[SCR_MASK_BIT] = irq_request_mask_ff;
      rdata[SCR_LATCH_BIT] = latch_ff;
    end else if (reg_hit(avs_address_i, OFS_OPT)) begin
      rdata[OPT_EN_BIT] = irq_function_enable_ff;
    end else if (reg_hit(avs_address_i, OFS_ISR)) begin
      rdata[EV_W-1:0] = ev_stat_ff;
    end else if (reg_hit(avs_address_i, OFS_IMR)) begin
      rdata[EV_W-1:0] = ev_mask_ff;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_function_enable_ff <= EN_RST;
    end else if (ce_i && wr_lane0 && reg_hit(acc.addr, OFS_OPT)) begin
      irq_function_enable_ff <= acc.wdata[OPT_EN_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sens_ff <= EIRQ_EDGE_ONLY; // RULE3
      irq_request_mask_ff <= MASK_RST;
    end else if (ce_i && wr_lane0 && reg_hit(acc.addr, OFS_SCR)) begin
      sens_ff <= eirq_sens_type'(acc.wdata[SCR_MODE_BIT]); // RULE3
      irq_request_mask_ff <= acc.wdata[SCR_MASK_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ev_mask_ff <= EV_RST;
    end else if (ce_i && wr_lane0 && reg_hit(acc.addr, OFS_IMR)) begin
      ev_mask_ff <= acc.wdata[EV_W-1:0];
    end
  end

  opt_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE1
    ce_i && wr_lane0 && acc.addr == OFS_OPT
    |=> irq_function_enable_ff == $past(acc.wdata[OPT_EN_BIT]))
    else $error("function enable write not applied");

  scr_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE3 RULE7
    ce_i && wr_lane0 && acc.addr == OFS_SCR
    |=> sens_ff == $past(acc.wdata[SCR_MODE_BIT]) && irq_request_mask_ff == $past(acc.wdata[SCR_MASK_BIT]))
    else $error("mode or local mask write not applied");

  imr_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && wr_lane0 && acc.addr == OFS_IMR
    |=> ev_mask_ff == $past(acc.wdata[EV_W-1:0]))
    else $error("event mask write not applied");

  // ----------------------------------------
  // Request latch
  // ----------------------------------------
  assign sw_ack = wr_lane0 && reg_hit(acc.addr, OFS_SCR) && acc.wdata[SCR_ACK_BIT]; // RULE5
  assign latch_set = pin_fall || (sens_ff == EIRQ_EDGE_LEVEL && pin_low); // RULE2 RULE3 RULE9
  assign latch_clr = vector_fetch_i || sw_ack; // RULE4 RULE5

  // Set beats clear, so a low pin in level mode survives an acknowledge
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      latch_ff <= 1'b0; // RULE6
    end else if (ce_i) begin
      if (latch_set) begin
        latch_ff <= 1'b1; // RULE2 RULE9
      end else if (latch_clr) begin
        latch_ff <= 1'b0; // RULE4 RULE5
      end
    end
  end

  latch_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE1
    ce_i && !irq_function_enable_ff && !latch_ff
    |=> !latch_ff)
    else $error("latch set while the pin function is off");

  latch_event_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE2
    ce_i && latch_set && !latch_ff
    |=> latch_ff && ev_stat_ff[EV_LATCH_BIT])
    else $error("latch rise not recorded as an event");

  level_ack_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE9
    ce_i && latch_clr && sens_ff == EIRQ_EDGE_LEVEL && pin_low
    |=> latch_ff)
    else $error("acknowledge cleared latch while pin held low");

  // ----------------------------------------
  // Outputs toward the processor and the port
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cpu_irq_req_ff <= 1'b0;
    end else if (ce_i) begin
      cpu_irq_req_ff <= latch_ff && !irq_request_mask_ff && !ccr_int_mask_i; // RULE7 RULE8
    end
  end

  req_forward_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE7 RULE8
    ce_i && latch_ff && !irq_request_mask_ff && !ccr_int_mask_i
    |=> cpu_irq_req_o)
    else $error("unmasked latched request not forwarded");

  mask_block_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE7
    ce_i && irq_request_mask_ff
    |=> !cpu_irq_req_o)
    else $error("request passed the local mask");

  // Port side sees the pin only while the interrupt function does not own it
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      active_ff <= EN_RST;
      port_ff <= PIN_IDLE;
    end else if (ce_i) begin
      active_ff <= irq_function_enable_ff; // RULE1
      port_ff <= irq_function_enable_ff ? PIN_IDLE : irq_pin_n_i; // RULE1
    end
  end

  port_owned_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE1
    ce_i && irq_function_enable_ff
    |=> shared_port_a_bit_two_o && irq_function_active_o)
    else $error("port side not released while function on");

  // ----------------------------------------
  // Event status, mask and interrupt line
  // ----------------------------------------
  assign ev_pulse[EV_LATCH_BIT] = latch_set && !latch_ff;
  assign ev_pulse[EV_ACK_BIT] = vector_fetch_i;

  genvar gi;
  generate
    for (gi = 0; gi < EV_W; gi++) begin : g_ev
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          ev_stat_ff[gi] <= 1'b0;
        end else if (ce_i) begin
          if (ev_pulse[gi]) begin
            ev_stat_ff[gi] <= 1'b1;
          end else if (wr_lane0 && reg_hit(acc.addr, OFS_ISR) && acc.wdata[gi]) begin
            ev_stat_ff[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  fetch_event_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && vector_fetch_i
    |=> ev_stat_ff[EV_ACK_BIT])
    else $error("vector fetch not recorded as an event");

  stat_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && wr_lane0 && acc.addr == OFS_ISR && acc.wdata[EV_LATCH_BIT] && !ev_pulse[EV_LATCH_BIT]
    |=> !ev_stat_ff[EV_LATCH_BIT])
    else $error("latch event not cleared by write of one");

  ack_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && wr_lane0 && acc.addr == OFS_ISR && acc.wdata[EV_ACK_BIT] && !vector_fetch_i
    |=> !ev_stat_ff[EV_ACK_BIT])
    else $error("fetch event not cleared by write of one");

  stat_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && ev_stat_ff[EV_LATCH_BIT] && !(wr_lane0 && acc.addr == OFS_ISR)
    |=> ev_stat_ff[EV_LATCH_BIT])
    else $error("latch event dropped without a clear");

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      intr_ff <= 1'b0;
    end else if (ce_i) begin
      intr_ff <= |(ev_stat_ff & ev_mask_ff);
    end
  end

  assign cpu_irq_req_o = cpu_irq_req_ff;
  assign irq_function_active_o = active_ff;
  assign shared_port_a_bit_two_o = port_ff;
  assign intr_o = intr_ff;

  ce_freeze_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ce_i
    |=> $stable(latch_ff) && $stable(cpu_irq_req_o) && $stable(intr_o) && $stable(avs_waitrequest_o))
    else $error("state moved while clock enable low");

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  pin_owner_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE1
    ce_i && !irq_function_enable_ff |=> shared_port_a_bit_two_o == $past(irq_pin_n_i) && !irq_function_active_o)
    else $error("shared pin not handed to port while function off");

  latch_capture_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE2
    ce_i && irq_function_enable_ff && $past(irq_pin_n_i) && !irq_pin_n_i && $past(irq_function_enable_ff)
    && $past(ce_i) |=> latch_ff)
    else $error("falling edge not latched");

  edge_only_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE3
    ce_i && sens_ff == EIRQ_EDGE_ONLY && !latch_ff && !pin_fall |=> !latch_ff)
    else $error("latch set without an edge in edge mode");

  fetch_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE4
    ce_i && vector_fetch_i && !latch_set |=> !latch_ff)
    else $error("vector fetch did not clear latch");

  sw_ack_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE5
    ce_i && sw_ack && !latch_set |=> !latch_ff)
    else $error("software acknowledge did not clear latch");

  latch_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE6
    latch_ff && !(ce_i && latch_clr) |=> latch_ff)
    else $error("latch dropped without a clear");

  reset_clear_a: assert property (@(posedge clk_i) // RULE6
    !rst_n_i |=> !latch_ff && !cpu_irq_req_o && sens_ff == EIRQ_EDGE_ONLY)
    else $error("reset did not clear latch");

  local_mask_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE7
    cpu_irq_req_o && $past(ce_i) |-> $past(latch_ff) && !$past(irq_request_mask_ff))
    else $error("masked request forwarded");

  global_mask_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE8
    ce_i && ccr_int_mask_i |=> !cpu_irq_req_o)
    else $error("request passed global mask");

  level_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE9
    ce_i && sens_ff == EIRQ_EDGE_LEVEL && irq_function_enable_ff && !irq_pin_n_i |=> latch_ff)
    else $error("low pin in level mode left request clear");

  int_line_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i |=> intr_o == |($past(ev_stat_ff) & $past(ev_mask_ff)))
    else $error("interrupt line disagrees with status and mask");

  bus_answer_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("slave answer not one cycle after request");
endmodule

// file: src/eirq_pkg.sv
package eirq_pkg;

  // ----------------------------------------
  // Bus shape
  // ----------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W = 4;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFS_SCR = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_OPT = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_ISR = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_IMR = 4'hc;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned SCR_ACK_BIT = 0;
  localparam int unsigned SCR_MODE_BIT = 1;
  localparam int unsigned SCR_MASK_BIT = 2;
  localparam int unsigned SCR_LATCH_BIT = 3;
  localparam int unsigned OPT_EN_BIT = 0;
  localparam int unsigned EV_LATCH_BIT = 0;
  localparam int unsigned EV_ACK_BIT = 1;
  localparam int unsigned EV_W = 2;
  localparam int unsigned LANE0_BIT = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic MASK_RST = 1'b0;
  localparam logic EN_RST = 1'b0;
  localparam logic PIN_IDLE = 1'b1;
  localparam logic [EV_W-1:0] EV_RST = 2'h0;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic {
    EIRQ_EDGE_ONLY = 1'b0,
    EIRQ_EDGE_LEVEL = 1'b1
  } eirq_sens_type;

  typedef enum logic {
    EIRQ_SLV_WAIT = 1'b0,
    EIRQ_SLV_DONE = 1'b1
  } eirq_slv_state_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [BE_W-1:0] be;
  } eirq_acc_type;

endpackage

// file: src/eirq_pin_sense.sv
module eirq_pin_sense (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic enable_i,
  input wire logic pin_n_i,
  output logic fall_o,
  output logic low_o
);
  import eirq_pkg::*;

  logic prev_ff;

  // Idle level while the function is off, so enabling it over a low pin
  // reports that as one falling edge.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev_ff <= PIN_IDLE;
    end else if (ce_i) begin
      prev_ff <= enable_i ? pin_n_i : PIN_IDLE;
    end
  end

  assign fall_o = enable_i & prev_ff & ~pin_n_i;
  assign low_o = enable_i & ~pin_n_i;
endmodule

// file: src/eirq_avs_slave.sv
module eirq_avs_slave (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [eirq_pkg::ADDR_W-1:0] address_i,
  input wire logic [eirq_pkg::DATA_W-1:0] writedata_i,
  input wire logic [eirq_pkg::BE_W-1:0] byteenable_i,
  input wire logic [eirq_pkg::DATA_W-1:0] rdata_i,
  output eirq_pkg::eirq_acc_type acc_o,
  output logic [eirq_pkg::DATA_W-1:0] readdata_o,
  output logic waitrequest_o
);
  import eirq_pkg::*;

  eirq_slv_state_type state_ff;
  eirq_slv_state_type nxt_state;
  logic waitrequest_ff;
  logic [DATA_W-1:0] readdata_ff;

  // ----------------------------------------
  // One wait cycle, then the answer
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      EIRQ_SLV_WAIT: begin
        if (read_i || write_i) begin
          nxt_state = EIRQ_SLV_DONE;
        end
      end
      EIRQ_SLV_DONE: begin
        nxt_state = EIRQ_SLV_WAIT;
      end
      default: begin
        nxt_state = EIRQ_SLV_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff <= EIRQ_SLV_WAIT;
      waitrequest_ff <= 1'b1;
    end else if (ce_i) begin
      state_ff <= nxt_state;
      waitrequest_ff <= (nxt_state != EIRQ_SLV_DONE);
    end
  end

  // Read data is caught as the answer is raised; no register has read side effects
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      readdata_ff <= RDATA_ZERO;
    end else if (ce_i && state_ff == EIRQ_SLV_WAIT && read_i) begin
      readdata_ff <= rdata_i;
    end
  end

  always_comb begin
    acc_o.rd = read_i && (state_ff == EIRQ_SLV_DONE);
    acc_o.wr = write_i && (state_ff == EIRQ_SLV_DONE);
    acc_o.addr = address_i;
    acc_o.wdata = writedata_i;
    acc_o.be = byteenable_i;
  end

  assign readdata_o = readdata_ff;
  assign waitrequest_o = waitrequest_ff;
endmodule

// file: test/eirq_src_model.sv
// ------------------------------
// External request source
// ------------------------------
module eirq_src_model (
  input wire logic clk_i,
  input wire logic hold_i,
  input wire logic go_i,
  input wire logic [7:0] len_i,
  output logic pin_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff = 8'h00;
  always @(posedge clk_i) begin
    if (go_i) begin
      cnt_ff <= len_i;
    end else if (cnt_ff != 8'h00) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end
  // Released pin is driven high at once, never keeps a stale low
  assign pin_n_o = (hold_i || cnt_ff != 8'h00) ? 1'b0 : 1'b1;
endmodule

// file: test/test_external_irq_latch.sv
module test_external_irq_latch;
  timeunit 1ns;
  timeprecision 1ps;
  import eirq_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n, rd_s, wr_s, vf, gm, hold, go;
  logic [3:0] addr, be_s;
  logic [31:0] wdata, q;
  logic [7:0] len;
  logic pin_n;
  logic ce;
  logic [31:0] rdata;
  logic wait_s, req, act, port, intr;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  always #5 clk_i = ~clk_i;

  eirq_src_model eirq_src_model_i (.clk_i(clk_i), .hold_i(hold), .go_i(go), .len_i(len), .pin_n_o(pin_n));
  eirq_top eirq_top_i (.clk_i(clk_i), .rst_n_i(rst_n), .ce_i(ce), .avs_address_i(addr),
    .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdata), .avs_byteenable_i(be_s),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_s), .irq_pin_n_i(pin_n), .vector_fetch_i(vf),
    .ccr_int_mask_i(gm), .cpu_irq_req_o(req), .irq_function_active_o(act),
    .shared_port_a_bit_two_o(port), .intr_o(intr));

  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic test_done();
    if (err_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under 5000 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Expected control word from the field values
  function automatic logic [31:0] exp_scr(input logic mode, input logic mask, input logic latch);
    exp_scr = 32'h0000_0000;
    exp_scr[SCR_MODE_BIT] = mode;
    exp_scr[SCR_MASK_BIT] = mask;
    exp_scr[SCR_LATCH_BIT] = latch;
  endfunction

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk_i);
    rd_s <= !w;
    wr_s <= w;
    addr <= a;
    wdata <= d;
    be_s <= b;
    do @(posedge clk_i); while (wait_s !== 1'b0);
    q = rdata;
    rd_s <= 1'b0;
    wr_s <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic rdchk(input string nm, input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, 4'hf);
    chk(nm, e, q);
  endtask

  task automatic pulse(input logic [7:0] n);
    @(posedge clk_i);
    go <= 1'b1;
    len <= n;
    @(posedge clk_i);
    go <= 1'b0;
    idle(n + 4);
  endtask

  task automatic fetch();
    @(posedge clk_i);
    vf <= 1'b1;
    @(posedge clk_i);
    vf <= 1'b0;
  endtask

  // ------------------------------
  // Sequence
  // ------------------------------
  initial begin
    rst_n = 1'b0; rd_s = 1'b0; wr_s = 1'b0; vf = 1'b0; gm = 1'b0; hold = 1'b0; go = 1'b0;
    addr = 4'h0; be_s = 4'hf; wdata = 32'h0000_0000; len = 8'h00;
    ce = 1'b1;
    q = $urandom(69125);
    idle(20);
    rst_n <= 1'b1;
    rdchk("scr_rst", OFS_SCR, 32'h0000_0000);
    rdchk("opt_rst", OFS_OPT, 32'h0000_0000);
    rdchk("unmapped", 4'h2, 32'h0000_0000);
    hold <= 1'b1;
    idle(4);
    chk("port_low", 32'h0, {31'h0, port});
    rdchk("scr_off", OFS_SCR, 32'h0000_0000);
    hold <= 1'b0;
    idle(2);
    bus(1'b1, OFS_OPT, 32'h0000_0001, 4'h0);
    rdchk("opt_be0", OFS_OPT, 32'h0000_0000);
    wr(OFS_OPT, 32'h0000_0001);
    idle(2);
    chk("func_act", 32'h1, {31'h0, act});
    chk("port_en", 32'h1, {31'h0, port});
    rdchk("opt_on", OFS_OPT, 32'h0000_0001);
    wr(OFS_IMR, 32'h0000_0001);
    rdchk("imr_rb", OFS_IMR, 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      pulse(8'($urandom_range(1, 6)));
      rdchk("latch_set", OFS_SCR, exp_scr(1'b0, 1'b0, 1'b1));
      chk("req_on", 32'h1, {31'h0, req});
      chk("intr_on", 32'h1, {31'h0, intr});
      if (i % 2 == 1) begin
        wr(OFS_SCR, 32'h0000_0001);
      end else begin
        fetch();
      end
      idle(3);
      rdchk("latch_clr", OFS_SCR, exp_scr(1'b0, 1'b0, 1'b0));
      chk("req_off", 32'h0, {31'h0, req});
      rdchk("isr_ev", OFS_ISR, (i % 2 == 1) ? 32'h0000_0001 : 32'h0000_0003);
      wr(OFS_ISR, 32'h0000_0003);
      idle(3);
      chk("intr_clr", 32'h0, {31'h0, intr});
    end
    wr(OFS_SCR, 32'h0000_0004);
    pulse(8'h02);
    rdchk("masked_latch", OFS_SCR, 32'h0000_000c);
    chk("req_masked", 32'h0, {31'h0, req});
    wr(OFS_SCR, 32'h0000_0000);
    idle(3);
    chk("req_unmask", 32'h1, {31'h0, req});
    gm <= 1'b1;
    idle(3);
    chk("req_global", 32'h0, {31'h0, req});
    gm <= 1'b0;
    idle(3);
    chk("req_back", 32'h1, {31'h0, req});
    wr(OFS_SCR, 32'h0000_0001);
    hold <= 1'b1;
    idle(4);
    wr(OFS_SCR, 32'h0000_0001);
    idle(3);
    rdchk("edge_once", OFS_SCR, 32'h0000_0000);
    wr(OFS_SCR, 32'h0000_0002);
    idle(3);
    rdchk("level_set", OFS_SCR, 32'h0000_000a);
    wr(OFS_SCR, 32'h0000_0003);
    idle(3);
    rdchk("level_keep", OFS_SCR, 32'h0000_000a);
    chk("req_level", 32'h1, {31'h0, req});
    hold <= 1'b0;
    idle(2);
    wr(OFS_SCR, 32'h0000_0003);
    idle(3);
    rdchk("level_ack", OFS_SCR, 32'h0000_0002);
    ce <= 1'b0;
    pulse(8'h02);
    ce <= 1'b1;
    idle(2);
    rdchk("ce_hold", OFS_SCR, exp_scr(1'b1, 1'b0, 1'b0));
    chk("req_ce_hold", 32'h0, {31'h0, req});
    wr(OFS_ISR, 32'h0000_0003);
    wr(OFS_IMR, 32'h0000_0000);
    pulse(8'h03);
    chk("intr_masked", 32'h0, {31'h0, intr});
    @(posedge clk_i);
    rst_n <= 1'b0;
    idle(2);
    rst_n <= 1'b1;
    rdchk("scr_rerst", OFS_SCR, 32'h0000_0000);
    chk("req_rerst", 32'h0, {31'h0, req});
    test_done();
  end
endmodule
